// ==== logic/pci_cfg_defs.svh ====
// Offsets, field positions, reset values and timing for the config block
`ifndef PCI_CFG_DEFS_SVH
`define PCI_CFG_DEFS_SVH

// ----------------------------------------------------------------
// Configuration offsets (byte addresses, dword aligned)
// ----------------------------------------------------------------
`define CFG_OFF_BASE4      8'h20
`define CFG_OFF_BASE5      8'h24
`define CFG_OFF_CARD_INFO  8'h28
`define CFG_OFF_SUBSYS     8'h2c
`define CFG_OFF_EXP_MEM    8'h30
`define CFG_OFF_RSVD_LOW   8'h34
`define CFG_OFF_RSVD_HIGH  8'h38
`define CFG_OFF_LAT_INT    8'h3c
`define CFG_OFF_PWR_CAP    8'h40
`define CFG_OFF_PWR_CTL    8'h44

// ----------------------------------------------------------------
// Fixed read values
// ----------------------------------------------------------------
`define CFG_ZERO_WORD      32'h0000_0000
`define CFG_GRANT_UNIT_NS  250
`define CFG_MAX_LAT_NS     6000
`define CFG_MIN_GNT_NS     1000
`define CFG_MAX_LAT        8'(`CFG_MAX_LAT_NS / `CFG_GRANT_UNIT_NS)
`define CFG_MIN_GNT        8'(`CFG_MIN_GNT_NS / `CFG_GRANT_UNIT_NS)
`define CFG_INT_PIN        8'h01
`define CFG_CAP_ID         8'h01
`define CFG_NEXT_PTR       8'h00
`define CFG_PWR_CAP_FIELD  16'h7e29

// ----------------------------------------------------------------
// Power control/status field positions and resets
// ----------------------------------------------------------------
`define PCS_STATE_LSB      0
`define PCS_WAKE_EN_BIT    8
`define PCS_WAKE_ST_BIT    15
`define PCS_STATE_RST      2'h0
`define INT_LINE_RST       8'h00

`endif

// ==== logic/pci_cfg_pkg.sv ====
// Types shared by the config, power and interrupt block
package pci_cfg_pkg;
	localparam int N_STREAMS = 4;
	localparam int N_VCHAN   = 16;
	localparam int POS_W     = 12;

	typedef logic [POS_W-1:0] pos_t;
	typedef logic [3:0]       vchan_t;

	typedef enum logic [1:0] {
		PWR_D0     = 2'h0,
		PWR_D1     = 2'h1,
		PWR_D2     = 2'h2,
		PWR_D3_HOT = 2'h3
	} pwr_state_e;
endpackage : pci_cfg_pkg

// ==== logic/pci_config_pm_interrupt.sv ====
// Upper config header, power management and interrupt aggregation
`timescale 1ns/100ps
`include "pci_cfg_defs.svh"
module pci_config_pm_interrupt (
	// Clock and reset
	input  wire logic                                  mclk,
	input  wire logic                                  arst_n,
	// Configuration access
	input  wire logic                                  cfg_rd,
	input  wire logic                                  cfg_wr,
	input  wire logic [7:0]                            cfg_addr,
	input  wire logic [3:0]                            cfg_be,
	input  wire logic [31:0]                           cfg_wdata,
	output logic [31:0]                                cfg_rdata,
	output logic                                       cfg_ack,
	// Config memory loader result
	input  wire logic                                  ee_done,
	input  wire logic                                  ee_sig_ok,
	input  wire logic [15:0]                           ee_ssid,
	input  wire logic [15:0]                           ee_ssvid,
	// Host programming of subsystem identifiers
	input  wire logic                                  ssid_wr,
	input  wire logic [31:0]                           ssid_wdata,
	// Stream pointers
	input  wire logic [pci_cfg_pkg::N_STREAMS-1:0]     str_valid,
	input  wire pci_cfg_pkg::pos_t [pci_cfg_pkg::N_STREAMS-1:0] str_pos,
	input  wire pci_cfg_pkg::pos_t [pci_cfg_pkg::N_STREAMS-1:0] str_size,
	input  wire pci_cfg_pkg::vchan_t [pci_cfg_pkg::N_STREAMS-1:0] str_vc,
	// Processor messages
	input  wire logic                                  msg_valid,
	input  wire pci_cfg_pkg::vchan_t                   msg_vc,
	// Interrupt control
	input  wire logic [pci_cfg_pkg::N_VCHAN-1:0]       int_enable,
	input  wire logic [pci_cfg_pkg::N_VCHAN-1:0]       int_clear,
	output logic [pci_cfg_pkg::N_VCHAN-1:0]            int_pending,
	output logic                                       inta_o,
	output logic                                       inta_oe,
	// Power management
	input  wire logic                                  wake_event,
	output pci_cfg_pkg::pwr_state_e                    power_state,
	output logic                                       external_config_memory_present
);
	import pci_cfg_pkg::*;

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_meta_ff;
	logic rst_n;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_ff <= 1'b0;
			rst_n       <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n       <= rst_meta_ff;
		end
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0]        rdata;
		logic               ack;
		logic               present;
		logic               programmed;
		logic [15:0]        ssid;
		logic [15:0]        ssvid;
		logic [7:0]         int_line;
		pwr_state_e         pstate;
		logic               wake_en;
		logic               wake_st;
		logic [N_VCHAN-1:0] pend;
		logic               int_oe;
		logic               int_o;
	} cfg_s;

	cfg_s                  st_ff;
	cfg_s                  nxt_st;
	logic [N_STREAMS-1:0]  str_hit;
	logic [N_VCHAN-1:0]    vc_set;
	logic [7:0]            dw;

	// ----------------------------------------------------------------
	// Stream watchers
	// ----------------------------------------------------------------
	for (genvar i = 0; i < N_STREAMS; i++) begin : g_str
		vchan_detect u_det (
			.mclk      (mclk),
			.rst_n     (rst_n),
			.pos_valid (str_valid[i]),
			.pos       (str_pos[i]),
			.size      (str_size[i]),
			.hit       (str_hit[i])
		);
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		dw     = {cfg_addr[7:2], 2'h0};
		vc_set = '0;

		// Channel events from streams and messages
		for (int i = 0; i < N_STREAMS; i++) begin
			if (str_hit[i]) begin
				vc_set[str_vc[i]] = 1'b1;
			end
		end
		if (msg_valid) begin
			vc_set[msg_vc] = 1'b1;
		end
		// Set wins over a clear in the same cycle
		nxt_st.pend = (st_ff.pend & ~int_clear) | vc_set;

		// Loader result; a bad signature loads nothing
		if (ee_done && ee_sig_ok) begin
			nxt_st.present = 1'b1;
			nxt_st.ssid    = ee_ssid;
			nxt_st.ssvid   = ee_ssvid;
		end
		if (ssid_wr) begin
			nxt_st.programmed = 1'b1;
			nxt_st.ssid       = ssid_wdata[31:16];
			nxt_st.ssvid      = ssid_wdata[15:0];
		end

		// Answer every access one cycle later
		nxt_st.ack   = cfg_rd || cfg_wr;
		nxt_st.rdata = `CFG_ZERO_WORD;
		if (cfg_rd) begin
			case (dw)
				`CFG_OFF_SUBSYS: begin
					if (st_ff.present || st_ff.programmed) begin
						nxt_st.rdata = {st_ff.ssid, st_ff.ssvid};
					end
				end
				`CFG_OFF_LAT_INT: begin
					nxt_st.rdata = {`CFG_MAX_LAT, `CFG_MIN_GNT,
						`CFG_INT_PIN, st_ff.int_line};
				end
				`CFG_OFF_PWR_CAP: begin
					nxt_st.rdata = {`CFG_PWR_CAP_FIELD,
						`CFG_NEXT_PTR, `CFG_CAP_ID};
				end
				`CFG_OFF_PWR_CTL: begin
					// Data, bridge byte and reserved bits stay zero
					nxt_st.rdata[`PCS_WAKE_ST_BIT]  = st_ff.wake_st;
					nxt_st.rdata[`PCS_WAKE_EN_BIT]  = st_ff.wake_en;
					nxt_st.rdata[`PCS_STATE_LSB +: 2] = st_ff.pstate;
				end
				// Base slots, card info, expansion, reserved all zero
				default: begin
					nxt_st.rdata = `CFG_ZERO_WORD;
				end
			endcase
		end

		// Writes; only the stored fields take them
		if (cfg_wr && dw == `CFG_OFF_LAT_INT && cfg_be[0]) begin
			nxt_st.int_line = cfg_wdata[7:0];
		end
		if (cfg_wr && dw == `CFG_OFF_PWR_CTL) begin
			if (cfg_be[0]) begin
				nxt_st.pstate =
					pwr_state_e'(cfg_wdata[`PCS_STATE_LSB +: 2]);
			end
			if (cfg_be[1]) begin
				nxt_st.wake_en = cfg_wdata[`PCS_WAKE_EN_BIT];
				if (cfg_wdata[`PCS_WAKE_ST_BIT]) begin
					nxt_st.wake_st = 1'b0;
				end
			end
		end
		// Wake event beats a same-cycle clear
		if (wake_event && st_ff.wake_en) begin
			nxt_st.wake_st = 1'b1;
		end

		// Open drain: pin pulled low while any enabled source pends
		nxt_st.int_oe = |(nxt_st.pend & int_enable);
		nxt_st.int_o  = 1'b0;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff          <= '0;
			st_ff.int_line <= `INT_LINE_RST;
			st_ff.pstate   <= pwr_state_e'(`PCS_STATE_RST);
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign cfg_rdata   = st_ff.rdata;
	assign cfg_ack     = st_ff.ack;
	assign int_pending = st_ff.pend;
	assign inta_o      = st_ff.int_o;
	assign inta_oe     = st_ff.int_oe;
	assign power_state = st_ff.pstate;
	assign external_config_memory_present = st_ff.present;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	property p_base_zero;
		cfg_rd && (dw == `CFG_OFF_BASE4 || dw == `CFG_OFF_BASE5)
			|=> cfg_ack && cfg_rdata == `CFG_ZERO_WORD;
	endproperty
	a_base_zero: assert property (p_base_zero)
		else $error("base slot not zero");

	property p_card_zero;
		cfg_rd && dw == `CFG_OFF_CARD_INFO |=> cfg_rdata == `CFG_ZERO_WORD;
	endproperty
	a_card_zero: assert property (p_card_zero)
		else $error("card pointer not zero");

	property p_ssid_absent;
		cfg_rd && dw == `CFG_OFF_SUBSYS && !st_ff.present &&
			!st_ff.programmed |=> cfg_rdata == `CFG_ZERO_WORD;
	endproperty
	a_ssid_absent: assert property (p_ssid_absent)
		else $error("subsystem ids not zero");

	property p_ssid_prog;
		ssid_wr ##1 (cfg_rd && dw == `CFG_OFF_SUBSYS && !ssid_wr && !ee_done)
			|=> cfg_rdata == $past(ssid_wdata, 2);
	endproperty
	a_ssid_prog: assert property (p_ssid_prog)
		else $error("programmed ids not returned");

	property p_exp_zero;
		cfg_rd && dw == `CFG_OFF_EXP_MEM |=> cfg_rdata == `CFG_ZERO_WORD;
	endproperty
	a_exp_zero: assert property (p_exp_zero)
		else $error("expansion base not zero");

	property p_lat_int;
		cfg_rd && dw == `CFG_OFF_LAT_INT
			|=> cfg_rdata[31:8] == 24'h180401;
	endproperty
	a_lat_int: assert property (p_lat_int)
		else $error("latency grant pin wrong");

	property p_cap;
		cfg_rd && dw == `CFG_OFF_PWR_CAP |=> cfg_rdata == 32'h7e29_0001;
	endproperty
	a_cap: assert property (p_cap)
		else $error("capability word wrong");

	property p_pcs_rsvd;
		cfg_rd && dw == `CFG_OFF_PWR_CTL
			|=> cfg_rdata[31:16] == 16'h0000 && cfg_rdata[14:9] == 6'h00 &&
				cfg_rdata[7:2] == 6'h00;
	endproperty
	a_pcs_rsvd: assert property (p_pcs_rsvd)
		else $error("read-zero power fields set");

	property p_pstate_wr;
		cfg_wr && dw == `CFG_OFF_PWR_CTL && cfg_be[0]
			|=> power_state == $past(cfg_wdata[1:0]);
	endproperty
	a_pstate_wr: assert property (p_pstate_wr)
		else $error("power state not written");

	property p_int_level;
		##1 inta_oe == |(int_pending & $past(int_enable));
	endproperty
	a_int_level: assert property (p_int_level)
		else $error("interrupt level mismatch");

	property p_msg;
		msg_valid |=> int_pending[$past(msg_vc)];
	endproperty
	a_msg: assert property (p_msg)
		else $error("message channel not pending");

	property p_bad_sig;
		ee_done && !ee_sig_ok && !st_ff.present
			|=> !external_config_memory_present;
	endproperty
	a_bad_sig: assert property (p_bad_sig)
		else $error("bad signature loaded ids");

	c_msg:   cover property (msg_valid ##1 inta_oe);
	c_str:   cover property (|str_hit ##1 |int_pending);
	c_load:  cover property (ee_done && ee_sig_ok ##1 cfg_rd);
	c_wake:  cover property (wake_event && st_ff.wake_en);
endmodule : pci_config_pm_interrupt

// ==== logic/vchan_detect.sv ====
// Circular buffer pointer watcher: flags mid-point crossings and wraps
`timescale 1ns/100ps
module vchan_detect (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              rst_n,
	// Pointer from the transfer engine
	input  wire logic              pos_valid,
	input  wire pci_cfg_pkg::pos_t pos,
	input  wire pci_cfg_pkg::pos_t size,
	// Event
	output logic                   hit
);
	import pci_cfg_pkg::*;

	typedef struct packed {
		logic seen;
		pos_t last;
	} det_s;

	det_s det_ff;
	det_s nxt_det;
	pos_t half;

	always_comb begin
		half    = size >> 1;
		nxt_det = det_ff;
		hit     = 1'b0;
		if (pos_valid) begin
			// First sample only primes the history
			hit = det_ff.seen && ((det_ff.last < half && pos >= half) ||
				(pos < det_ff.last));
			nxt_det.seen = 1'b1;
			nxt_det.last = pos;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			det_ff <= '0;
		end else begin
			det_ff <= nxt_det;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_wrap_hit;
		@(posedge mclk) disable iff (!rst_n)
		(pos_valid && det_ff.seen && pos < det_ff.last) |-> hit;
	endproperty
	a_wrap_hit: assert property (p_wrap_hit)
		else $error("wrap not signalled");
endmodule : vchan_detect

// ==== sim/cfg_host_model.sv ====
// Host bridge model issuing configuration reads and writes
`timescale 1ns/100ps
module cfg_host_model (
	// Clock
	input  wire logic        mclk,
	// Configuration access
	output logic             cfg_rd,
	output logic             cfg_wr,
	output logic [7:0]       cfg_addr,
	output logic [3:0]       cfg_be,
	output logic [31:0]      cfg_wdata,
	input  wire logic [31:0] cfg_rdata,
	input  wire logic        cfg_ack
);
	initial begin
		cfg_rd    = 1'b0;
		cfg_wr    = 1'b0;
		cfg_addr  = 8'h00;
		cfg_be    = 4'h0;
		cfg_wdata = 32'h0000_0000;
	end

	// Released lines carry inverted values so a stale sample never matches
	task automatic cfg_read(input logic [7:0] a, output logic [31:0] d,
		output logic ok);
		@(posedge mclk);
		#1;
		cfg_rd   = 1'b1;
		cfg_addr = a;
		@(posedge mclk);
		#1;
		cfg_rd   = 1'b0;
		cfg_addr = ~a;
		ok       = cfg_ack;
		d        = cfg_rdata;
	endtask : cfg_read

	task automatic cfg_write(input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d, output logic ok);
		@(posedge mclk);
		#1;
		cfg_wr    = 1'b1;
		cfg_addr  = a;
		cfg_be    = be;
		cfg_wdata = d;
		@(posedge mclk);
		#1;
		cfg_wr    = 1'b0;
		cfg_addr  = ~a;
		cfg_be    = ~be;
		cfg_wdata = ~d;
		ok        = cfg_ack;
	endtask : cfg_write
endmodule : cfg_host_model

// ==== sim/pci_config_pm_interrupt_tb_top.sv ====
// Self-checking bench for the config, power and interrupt block
`timescale 1ns/100ps
module pci_config_pm_interrupt_tb_top;
	import pci_cfg_pkg::*;
	logic                           mclk, arst_n, cfg_rd, cfg_wr, cfg_ack;
	logic [7:0]                     cfg_addr;
	logic [3:0]                     cfg_be;
	logic [31:0]                    cfg_wdata, cfg_rdata, ssid_wdata;
	logic                           ee_done, ee_sig_ok, ssid_wr;
	logic [15:0]                    ee_ssid, ee_ssvid;
	logic [N_STREAMS-1:0]           str_valid;
	pos_t [N_STREAMS-1:0]           str_pos, str_size;
	vchan_t [N_STREAMS-1:0]         str_vc;
	logic                           msg_valid, inta_o, inta_oe, wake_event;
	vchan_t                         msg_vc;
	logic [N_VCHAN-1:0]             int_enable, int_clear, int_pending;
	pwr_state_e                     power_state;
	logic                           external_config_memory_present;
	int                             err_total, n_tests;
	logic [31:0]                    rd_v;
	logic                           ok;
	// Unmapped 0x48 last; 0x18 = 6 us and 0x04 = 1 us in 250 ns units
	localparam logic [7:0]  OFFS [11] = '{8'h20, 8'h24, 8'h28, 8'h2c,
		8'h30, 8'h34, 8'h38, 8'h3c, 8'h40, 8'h44, 8'h48};
	localparam logic [31:0] RST_V [11] = '{0, 0, 0, 0, 0, 0, 0,
		32'h1804_0100, 32'h7e29_0001, 0, 0};
	localparam logic [31:0] AFT_V [11] = '{0, 0, 0, 0, 0, 0, 0,
		32'h1804_01ff, 32'h7e29_0001, 32'h0000_0103, 0};
	localparam int          PTR [5] = '{0, 31, 32, 40, 10};
	localparam logic        HIT [5] = '{0, 0, 1, 0, 1};

	cfg_host_model u_host (.mclk, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be,
		.cfg_wdata, .cfg_rdata, .cfg_ack);

	pci_config_pm_interrupt u_dut (.mclk, .arst_n, .cfg_rd, .cfg_wr,
		.cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack, .ee_done,
		.ee_sig_ok, .ee_ssid, .ee_ssvid, .ssid_wr, .ssid_wdata, .str_valid,
		.str_pos, .str_size, .str_vc, .msg_valid, .msg_vc, .int_enable,
		.int_clear, .int_pending, .inta_o, .inta_oe, .wake_event,
		.power_state, .external_config_memory_present);

	// ----------------------------------------------------------------
	// Clock, checks and closing
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		u_host.cfg_read(a, rd_v, ok);
		chk(32'(ok), 32'h1);
		chk(rd_v, exp);
	endtask : rd_chk

	task automatic wr(input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d);
		u_host.cfg_write(a, be, d, ok);
		chk(32'(ok), 32'h1);
	endtask : wr

	// One cycle on, then the registered effect is visible
	task automatic step();
		@(posedge mclk);
		#1;
	endtask : step

	task automatic clr(input logic [15:0] m);
		int_clear = m;
		step();
		int_clear = 16'h0;
		step();
		chk({int_pending, 14'h0, inta_oe, inta_o}, 32'h0);
	endtask : clr

	task automatic stop_test();
		if (err_total == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test

	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		stop_test();
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		{arst_n, ee_done, ee_sig_ok, ssid_wr, msg_valid, wake_event} = '0;
		{ee_ssid, ee_ssvid, ssid_wdata, int_enable, int_clear} = '0;
		{str_valid, str_pos, msg_vc, str_vc} = '0;
		str_size  = {N_STREAMS{12'd64}};
		err_total = 0;
		n_tests   = 0;
		repeat (6) @(posedge mclk);
		#1;
		arst_n = 1'b1;
		repeat (3) @(posedge mclk);
		for (int i = 0; i < 11; i++) begin
			rd_chk(OFFS[i], RST_V[i]);
		end
		for (int i = 0; i < 11; i++) begin
			wr(OFFS[i], 4'hf, 32'hffff_ffff);
			rd_chk(OFFS[i], AFT_V[i]);
		end
		wake_event = 1'b1;
		step();
		wake_event = 1'b0;
		rd_chk(8'h44, 32'h0000_8103);
		wr(8'h44, 4'h2, 32'h0000_8100);
		rd_chk(8'h44, 32'h0000_0103);
		wr(8'h44, 4'h2, 32'h0);
		wake_event = 1'b1;
		step();
		wake_event = 1'b0;
		rd_chk(8'h44, 32'h0000_0003);
		for (int i = 0; i < 4; i++) begin
			wr(8'h44, 4'h1, 32'(i));
			chk(32'(power_state), 32'(i));
			rd_chk(8'h44, 32'(i));
		end
		// Bad signature first, then a good load, then host programming
		{ee_done, ee_ssid, ee_ssvid} = {1'b1, 16'h1234, 16'h5678};
		step();
		ee_done = 1'b0;
		chk(32'(external_config_memory_present), 32'h0);
		rd_chk(8'h2c, 32'h0);
		{ee_done, ee_sig_ok} = 2'b11;
		step();
		{ee_done, ee_sig_ok} = 2'b00;
		chk(32'(external_config_memory_present), 32'h1);
		rd_chk(8'h2c, 32'h1234_5678);
		{ssid_wr, ssid_wdata} = {1'b1, 32'habcd_ef01};
		step();
		ssid_wr = 1'b0;
		rd_chk(8'h2c, 32'habcd_ef01);
		int_enable = 16'hffff;
		for (int i = 0; i < N_VCHAN; i++) begin
			{msg_valid, msg_vc} = {1'b1, vchan_t'(i)};
			step();
			{msg_valid, msg_vc} = {1'b0, ~vchan_t'(i)};
			chk({int_pending, 14'h0, inta_oe, inta_o},
				{16'h1 << i, 16'h2});
			clr(16'h1 << i);
		end
		// Masked source pends without driving the pin; set beats clear
		int_enable = 16'h0;
		{msg_valid, msg_vc, int_clear} = {1'b1, 4'h9, 16'h0200};
		step();
		{msg_valid, int_clear} = {1'b0, 16'h0};
		chk({int_pending, 15'h0, inta_oe}, {16'h0200, 16'h0});
		int_enable = 16'hffff;
		step();
		chk(32'(inta_oe), 32'h1);
		clr(16'h0200);
		for (int s = 0; s < N_STREAMS; s++) begin
			str_vc[s] = vchan_t'(s + 5);
			for (int k = 0; k < 5; k++) begin
				str_valid[s] = 1'b1;
				str_pos[s]   = pos_t'(PTR[k]);
				step();
				str_valid[s] = 1'b0;
				str_pos[s]   = ~str_pos[s];
				chk(32'(int_pending), HIT[k] ? 32'h1 << (s + 5) : 0);
				if (HIT[k]) begin
					clr(16'h1 << (s + 5));
				end
			end
		end
		stop_test();
	end
endmodule : pci_config_pm_interrupt_tb_top
